// [design/hdlchp_port.sv]
// Operation
// - Channel has a 64-byte receive FIFO and a 64-byte transmit FIFO.
// - Host accesses count only while channel chip select is low.
// - Each FIFO takes a 32-byte window of the address map.
// - Any address in a FIFO window reaches that FIFO's top byte.
// - Cause readable in channel or extended status; top status flags which.
// - Channel status holds three events, extended status the other five.
// - Masked events hidden from all status registers and interrupt line.
// - Masked events stay latched and show once the mask bit clears.
// - Eight sources: four receive, two transmit, two special conditions.
// - Separate receive and transmit DMA requests, one shared acknowledge.
// - Cycles with acknowledge reach the FIFO top, ignoring address and select.
// - Each DMA request stays active while its FIFO still needs transfers.
// - Transmit block of n bytes drops request at write rise of transfer n-1.
// - Long transmit drops request also at transfers 31, 63 and onward.
// - After a drop, request returns on acknowledge or select rise if bytes remain.
// - If the last byte already passed, request stays off until next block.
// - 32-byte receive blocks drop at read rise of transfer 31, then rearm.
// - Receive blocks are 4, 8, 16 or 32; short blocks drop at read fall.
// - First 32 received bytes raise pool full in interrupt mode; DMA mode requests per block.
// - In DMA mode reading a whole receive block confirms it implicitly.
`timescale 1ns/100ps
`default_nettype none
module hdlchp_port #(
  parameter int CNT_W = 16
) (
  input  wire logic                     mclk,          // 40 MHz clock
  input  wire logic                     rst_n,         // Async reset
  input  wire hdlchp_pkg::hdlchp_pins_t bus_pins,      // Host bus pins, async
  output logic                    [7:0] host_rdata,    // Read data to bus
  output logic                          host_rdata_oe, // Drive read data
  output logic                          int_n,         // Interrupt line
  output logic                          drq_rx,        // Receive DMA request
  output logic                          drq_tx,        // Transmit DMA request
  input  wire logic               [7:0] int_mask,      // 1 hides an event
  input  wire logic                     dma_mode,      // FIFOs served by DMA
  input  wire logic               [1:0] rx_blk_sel,    // Receive block length
  input  wire logic                     tx_start,      // Begin DMA message
  input  wire logic         [CNT_W-1:0] tx_byte_count, // Message length
  input  wire logic                     rx_confirm,    // Receive block confirm
  input  wire logic               [7:0] ev_in,         // Event pulses
  input  wire hdlchp_pkg::hdlchp_byte_t rx_push,       // Byte from receiver
  output logic                          rx_full,       // Receive FIFO full
  input  wire logic                     tx_pop,        // Transmitter takes byte
  output logic                    [7:0] tx_byte,       // Transmit FIFO head
  output logic                          tx_avail       // Transmit FIFO not empty
);

  typedef struct packed {
    hdlchp_pkg::hdlchp_pins_t s1;
    hdlchp_pkg::hdlchp_pins_t s2;
    hdlchp_pkg::hdlchp_pins_t s3;
    logic [7:0]               ev;
    logic [7:0]               snap;
    logic [6:0]               snap_addr;
    logic [7:0]               rdata;
    logic                     rdata_oe;
    logic                     int_n;
    logic                     pf_seen;
    logic [6:0]               rx_wr;
    logic [6:0]               rx_rd;
    logic [6:0]               rx_peek;
    logic [6:0]               tx_wr;
    logic [6:0]               tx_rd;
    logic [CNT_W-1:0]         tx_remain;
    logic [5:0]               tx_left;
    logic [5:0]               rx_left;
    logic [5:0]               rx_len;
    hdlchp_pkg::hdlchp_dma_t  tx_st;
    hdlchp_pkg::hdlchp_dma_t  rx_st;
    logic                     drq_rx;
    logic                     drq_tx;
    logic                     rx_full;
    logic                     tx_avail;
  } hdlchp_state_t;

  hdlchp_state_t st_reg;
  hdlchp_state_t st_next;

  logic [7:0] rx_q;       // Receive FIFO byte at peek pointer
  logic [7:0] vis;        // Latched events not hidden by mask
  logic [7:0] chan_view;  // Channel status layout
  logic [7:0] ext_view;   // Extended status layout
  logic [7:0] top_view;   // Top-level status layout
  logic [7:0] rd_mux;     // Read data selected by address
  logic       rd_rise;    // Completed read cycle
  logic       rd_fall;    // Started read cycle
  logic       wr_rise;    // Completed write cycle
  logic       sel_rise;   // Acknowledge or select released
  logic       dma_cyc;    // Cycle under acknowledge
  logic       host_cyc;   // Addressed cycle under chip select
  logic       rx_hit;     // Cycle reaches receive FIFO
  logic       tx_hit;     // Cycle reaches transmit FIFO
  logic       rx_pop;     // Host or DMA takes a receive byte
  logic       tx_push;    // Host or DMA puts a transmit byte
  logic       rx_wen;     // Receiver write accepted
  logic [6:0] rx_cnt;     // Bytes held, receive
  logic [6:0] rx_avail;   // Bytes not yet read, receive
  logic [6:0] rx_blk;     // Confirm size in interrupt mode
  logic [6:0] tx_cnt;     // Bytes held, transmit
  logic [6:0] tx_free;    // Space left, transmit
  logic [5:0] tx_blen;    // Next transmit block length
  logic [7:0] ev_set;     // Events raised this cycle
  logic [7:0] ev_clr;     // Events cleared by a status read

  // Both FIFOs share one memory module type; read data comes from a flop
  hdlchp_fifo_mem #(.DATA_W(8), .DEPTH(hdlchp_pkg::FIFO_DEPTH)) u_rx_mem (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .wr_en   (rx_wen),
    .wr_addr (st_reg.rx_wr[5:0]),
    .wr_data (rx_push.data),
    .rd_addr (st_reg.rx_peek[5:0]),
    .rd_data (rx_q)
  );

  hdlchp_fifo_mem #(.DATA_W(8), .DEPTH(hdlchp_pkg::FIFO_DEPTH)) u_tx_mem (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .wr_en   (tx_push),
    .wr_addr (st_reg.tx_wr[5:0]),
    .wr_data (st_reg.s3.wdata),
    .rd_addr (st_reg.tx_rd[5:0]),
    .rd_data (tx_byte)
  );

  // Strobe edges on the synchronised pins; s1 is only copied into s2
  always_comb begin
    rd_rise  = !st_reg.s3.rd_n && st_reg.s2.rd_n;
    rd_fall  = st_reg.s3.rd_n && !st_reg.s2.rd_n;
    wr_rise  = !st_reg.s3.wr_n && st_reg.s2.wr_n;
    sel_rise = (!st_reg.s3.dma_acknowledge_n && st_reg.s2.dma_acknowledge_n) ||
               (!st_reg.s3.cs_n && st_reg.s2.cs_n);
    dma_cyc  = !st_reg.s3.dma_acknowledge_n;
    host_cyc = !st_reg.s3.cs_n && st_reg.s3.dma_acknowledge_n;
    rx_hit   = dma_cyc ||
               (host_cyc && (st_reg.s3.addr & hdlchp_pkg::WIN_MASK) ==
                hdlchp_pkg::RX_WIN_BASE);
    tx_hit   = dma_cyc ||
               (host_cyc && (st_reg.s3.addr & hdlchp_pkg::WIN_MASK) ==
                hdlchp_pkg::TX_WIN_BASE);
  end

  // FIFO levels
  always_comb begin
    rx_cnt   = 7'(st_reg.rx_wr - st_reg.rx_rd);
    rx_avail = 7'(st_reg.rx_wr - st_reg.rx_peek);
    rx_blk   = (rx_cnt > hdlchp_pkg::HALF_CNT) ? hdlchp_pkg::HALF_CNT : rx_cnt;
    tx_cnt   = 7'(st_reg.tx_wr - st_reg.tx_rd);
    tx_free  = 7'(hdlchp_pkg::FIFO_FULL - tx_cnt);
    tx_blen  = (st_reg.tx_remain >= CNT_W'(hdlchp_pkg::BLK_LEN_MAX)) ?
               hdlchp_pkg::BLK_LEN_MAX : st_reg.tx_remain[5:0];
    rx_wen   = rx_push.valid && (rx_cnt != hdlchp_pkg::FIFO_FULL);
    rx_pop   = rd_rise && rx_hit && (rx_avail != 7'h00);
    tx_push  = wr_rise && tx_hit && (tx_cnt != hdlchp_pkg::FIFO_FULL);
  end

  // Status views: masked events hidden, yet still held in st_reg.ev
  always_comb begin
    vis       = st_reg.ev & ~int_mask;
    chan_view = {5'h00, vis[hdlchp_pkg::EV_POOL_READY],
                 vis[hdlchp_pkg::EV_MSG_END], vis[hdlchp_pkg::EV_POOL_FULL]};
    ext_view  = {3'h0, vis[hdlchp_pkg::EV_RX_OVERFLOW],
                 vis[hdlchp_pkg::EV_TX_UNDERRUN], vis[hdlchp_pkg::EV_MSG_REPEAT],
                 vis[hdlchp_pkg::EV_HDLC_EXT], vis[hdlchp_pkg::EV_FRAME_START]};
    top_view  = {6'h00, |ext_view, |chan_view};
    case (st_reg.s2.addr)
      hdlchp_pkg::CHAN_STAT_ADDR: rd_mux = chan_view;
      hdlchp_pkg::EXT_STAT_ADDR:  rd_mux = ext_view;
      hdlchp_pkg::TOP_STAT_ADDR:  rd_mux = top_view;
      default: begin
        rd_mux = ((st_reg.s2.addr & hdlchp_pkg::WIN_MASK) == hdlchp_pkg::RX_WIN_BASE) ?
                 rx_q : hdlchp_pkg::RDATA_RESET;
      end
    endcase
    if (!st_reg.s2.dma_acknowledge_n) begin
      rd_mux = rx_q;
    end
  end

  // Event set and read-to-clear; a new event in the clear cycle survives
  always_comb begin
    ev_set = ev_in;
    if (!dma_mode && st_reg.rx_st == hdlchp_pkg::DMA_IDLE && !st_reg.pf_seen &&
        rx_cnt >= hdlchp_pkg::HALF_CNT) begin
      ev_set[hdlchp_pkg::EV_POOL_FULL] = 1'b1;
    end
    ev_clr = 8'h00;
    if (rd_rise && host_cyc) begin
      if (st_reg.snap_addr == hdlchp_pkg::CHAN_STAT_ADDR) begin
        ev_clr[hdlchp_pkg::EV_POOL_FULL]  = st_reg.snap[0];
        ev_clr[hdlchp_pkg::EV_MSG_END]    = st_reg.snap[1];
        ev_clr[hdlchp_pkg::EV_POOL_READY] = st_reg.snap[2];
      end else if (st_reg.snap_addr == hdlchp_pkg::EXT_STAT_ADDR) begin
        ev_clr[hdlchp_pkg::EV_FRAME_START] = st_reg.snap[0];
        ev_clr[hdlchp_pkg::EV_HDLC_EXT]    = st_reg.snap[1];
        ev_clr[hdlchp_pkg::EV_MSG_REPEAT]  = st_reg.snap[2];
        ev_clr[hdlchp_pkg::EV_TX_UNDERRUN] = st_reg.snap[3];
        ev_clr[hdlchp_pkg::EV_RX_OVERFLOW] = st_reg.snap[4];
      end
    end
  end

  // Whole next state
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = bus_pins;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;

    // Events and interrupt line
    st_next.ev    = (st_reg.ev & ~ev_clr) | ev_set;
    st_next.int_n = ~|((st_next.ev) & ~int_mask);
    if (rx_cnt < hdlchp_pkg::HALF_CNT) begin
      st_next.pf_seen = 1'b0;
    end else if (ev_set[hdlchp_pkg::EV_POOL_FULL] || st_reg.rx_st != hdlchp_pkg::DMA_IDLE) begin
      st_next.pf_seen = 1'b1;
    end

    // Read data path; status bits are snapped at read start so the clear matches
    st_next.rdata_oe = !st_reg.s2.rd_n &&
                       (!st_reg.s2.dma_acknowledge_n || !st_reg.s2.cs_n);
    if (st_next.rdata_oe) begin
      st_next.rdata = rd_mux;
    end
    if (rd_fall) begin
      st_next.snap      = rd_mux;
      st_next.snap_addr = st_reg.s2.addr;
    end

    // Receive FIFO pointers
    if (rx_wen) begin
      st_next.rx_wr = 7'(st_reg.rx_wr + 7'h01);
    end
    if (rx_pop) begin
      st_next.rx_peek = 7'(st_reg.rx_peek + 7'h01);
      if (!dma_mode && 7'(st_reg.rx_peek + 7'h01 - st_reg.rx_rd) >= rx_blk) begin
        st_next.rx_peek = st_reg.rx_rd;  // Re-read block until confirmed
      end
    end
    if (!dma_mode && rx_confirm) begin
      st_next.rx_rd   = 7'(st_reg.rx_rd + rx_blk);
      st_next.rx_peek = 7'(st_reg.rx_rd + rx_blk);
    end
    st_next.rx_full = (7'(st_next.rx_wr - st_next.rx_rd) == hdlchp_pkg::FIFO_FULL);

    // Transmit FIFO pointers
    if (tx_push) begin
      st_next.tx_wr = 7'(st_reg.tx_wr + 7'h01);
    end
    if (tx_pop && tx_cnt != 7'h00) begin
      st_next.tx_rd = 7'(st_reg.tx_rd + 7'h01);
    end
    st_next.tx_avail = (st_next.tx_wr != st_next.tx_rd);

    // Receive DMA request
    case (st_reg.rx_st)
      hdlchp_pkg::DMA_IDLE: begin
        st_next.rx_len = hdlchp_pkg::rx_blk_len(rx_blk_sel);
        if (dma_mode && rx_avail >= {1'b0, st_next.rx_len}) begin
          st_next.rx_left = st_next.rx_len;
          st_next.rx_st   = hdlchp_pkg::DMA_REQ;
        end
      end
      hdlchp_pkg::DMA_REQ, hdlchp_pkg::DMA_WAIT: begin
        if (st_reg.rx_st == hdlchp_pkg::DMA_WAIT && sel_rise &&
            st_reg.rx_len == hdlchp_pkg::BLK_LEN_MAX && st_reg.rx_left != 6'h00) begin
          st_next.rx_st = hdlchp_pkg::DMA_REQ;
        end
        if (rd_fall && st_reg.rx_left == 6'h01 &&
            st_reg.rx_len != hdlchp_pkg::BLK_LEN_MAX &&
            (!st_reg.s2.dma_acknowledge_n || !st_reg.s2.cs_n)) begin
          st_next.rx_st = hdlchp_pkg::DMA_WAIT;
        end
        if (rx_pop) begin
          st_next.rx_left = 6'(st_reg.rx_left - 6'h01);
          if (st_reg.rx_left == 6'h02 && st_reg.rx_len == hdlchp_pkg::BLK_LEN_MAX) begin
            st_next.rx_st = hdlchp_pkg::DMA_WAIT;
          end
          if (st_reg.rx_left == 6'h01) begin
            st_next.rx_rd = st_next.rx_peek;
            st_next.rx_st = hdlchp_pkg::DMA_IDLE;
          end
        end
      end
      default: st_next.rx_st = hdlchp_pkg::DMA_IDLE;
    endcase

    // Transmit DMA request
    if (tx_start) begin
      st_next.tx_remain = tx_byte_count;
    end
    case (st_reg.tx_st)
      hdlchp_pkg::DMA_IDLE: begin
        if (dma_mode && !tx_start && st_reg.tx_remain != '0 &&
            tx_free >= {1'b0, tx_blen}) begin
          st_next.tx_left = tx_blen;
          st_next.tx_st   = hdlchp_pkg::DMA_REQ;
        end
      end
      hdlchp_pkg::DMA_REQ, hdlchp_pkg::DMA_WAIT: begin
        if (st_reg.tx_st == hdlchp_pkg::DMA_WAIT && sel_rise && st_reg.tx_left != 6'h00) begin
          st_next.tx_st = hdlchp_pkg::DMA_REQ;
        end
        if (tx_push) begin
          st_next.tx_left   = 6'(st_reg.tx_left - 6'h01);
          st_next.tx_remain = CNT_W'(st_reg.tx_remain - 1'b1);
          if (st_reg.tx_left == 6'h02) begin
            st_next.tx_st = hdlchp_pkg::DMA_WAIT;
          end
          if (st_reg.tx_left == 6'h01) begin
            st_next.tx_st = hdlchp_pkg::DMA_IDLE;
          end
        end
      end
      default: st_next.tx_st = hdlchp_pkg::DMA_IDLE;
    endcase

    // Requests are level outputs of the two machines
    st_next.drq_rx = (st_next.rx_st == hdlchp_pkg::DMA_REQ);
    st_next.drq_tx = (st_next.tx_st == hdlchp_pkg::DMA_REQ);
  end

  // Reset leaves pins idle, interrupt off and both requests low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg          <= '0;
      st_reg.s1       <= hdlchp_pkg::PINS_IDLE;
      st_reg.s2       <= hdlchp_pkg::PINS_IDLE;
      st_reg.s3       <= hdlchp_pkg::PINS_IDLE;
      st_reg.ev       <= hdlchp_pkg::EV_RESET;
      st_reg.rdata    <= hdlchp_pkg::RDATA_RESET;
      st_reg.int_n    <= 1'b1;
      st_reg.tx_st    <= hdlchp_pkg::DMA_IDLE;
      st_reg.rx_st    <= hdlchp_pkg::DMA_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign host_rdata    = st_reg.rdata;
  assign host_rdata_oe = st_reg.rdata_oe;
  assign int_n         = st_reg.int_n;
  assign drq_rx        = st_reg.drq_rx;
  assign drq_tx        = st_reg.drq_tx;
  assign rx_full       = st_reg.rx_full;
  assign tx_avail      = st_reg.tx_avail;

endmodule : hdlchp_port
`default_nettype wire

// [design/hdlchp_pkg.sv]
package hdlchp_pkg;

  // Host address map of one channel (7 address bits)
  localparam logic [6:0] RX_WIN_BASE    = 7'h00;
  localparam logic [6:0] TX_WIN_BASE    = 7'h20;
  localparam logic [6:0] WIN_MASK       = 7'h60;
  localparam logic [6:0] CHAN_STAT_ADDR = 7'h40;
  localparam logic [6:0] EXT_STAT_ADDR  = 7'h41;
  localparam logic [6:0] TOP_STAT_ADDR  = 7'h42;

  // Event vector bit positions
  localparam int EV_FRAME_START  = 0;
  localparam int EV_POOL_FULL    = 1;
  localparam int EV_MSG_END      = 2;
  localparam int EV_HDLC_EXT     = 3;
  localparam int EV_POOL_READY   = 4;
  localparam int EV_MSG_REPEAT   = 5;
  localparam int EV_TX_UNDERRUN  = 6;
  localparam int EV_RX_OVERFLOW  = 7;

  // FIFO geometry and reset values
  localparam int         FIFO_DEPTH   = 64;
  localparam int         PTR_W        = 7;
  localparam logic [6:0] FIFO_FULL    = 7'h40;
  localparam logic [6:0] HALF_CNT     = 7'h20;
  localparam logic [5:0] BLK_LEN_MAX  = 6'h20;
  localparam logic [7:0] EV_RESET     = 8'h00;
  localparam logic [7:0] RDATA_RESET  = 8'h00;

  // Bus pins as seen at the device
  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic       dma_acknowledge_n;
    logic [6:0] addr;
    logic [7:0] wdata;
  } hdlchp_pins_t;

  localparam hdlchp_pins_t PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                         dma_acknowledge_n: 1'b1, addr: 7'h00, wdata: 8'h00};

  // Byte pushed by the receive serial side
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } hdlchp_byte_t;

  typedef enum logic [1:0] {
    DMA_IDLE,
    DMA_REQ,
    DMA_WAIT
  } hdlchp_dma_t;

  // Receive DMA block length selector: 4, 8, 16 or 32 bytes
  function automatic logic [5:0] rx_blk_len(input logic [1:0] sel);
    case (sel)
      2'h0:    rx_blk_len = 6'h04;
      2'h1:    rx_blk_len = 6'h08;
      2'h2:    rx_blk_len = 6'h10;
      default: rx_blk_len = 6'h20;
    endcase
  endfunction : rx_blk_len

endpackage : hdlchp_pkg

// [design/hdlchp_fifo_mem.sv]
`timescale 1ns/100ps
`default_nettype none
module hdlchp_fifo_mem #(
  parameter int DATA_W = 8,
  parameter int DEPTH  = 64,
  parameter int ADDR_W = $clog2(DEPTH)
) (
  input  wire logic              mclk,    // System clock
  input  wire logic              rst_n,   // Async reset
  input  wire logic              wr_en,   // Write strobe
  input  wire logic [ADDR_W-1:0] wr_addr, // Write address
  input  wire logic [DATA_W-1:0] wr_data, // Write data
  input  wire logic [ADDR_W-1:0] rd_addr, // Read address
  output logic      [DATA_W-1:0] rd_data  // Registered read data
);

  typedef struct packed {
    logic [DEPTH-1:0][DATA_W-1:0] mem;
    logic [DATA_W-1:0]            q;
  } hdlchp_mem_st_t;

  hdlchp_mem_st_t st_reg;
  hdlchp_mem_st_t st_next;

  // Read data always registered, so the read port never sees a write in flight
  always_comb begin
    st_next   = st_reg;
    st_next.q = st_reg.mem[rd_addr];
    if (wr_en) begin
      st_next.mem[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data = st_reg.q;

endmodule : hdlchp_fifo_mem
`default_nettype wire

// [test/hdlchp_port_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module hdlchp_port_properties #(
  parameter int CNT_W = 16
) (
  input wire logic                     mclk,          // Clock
  input wire logic                     rst_n,         // Reset
  input wire hdlchp_pkg::hdlchp_pins_t bus_pins,      // Bus pins
  input wire logic                     host_rdata_oe, // Read drive
  input wire logic                     int_n,         // Interrupt
  input wire logic                     drq_rx,        // Rx request
  input wire logic                     drq_tx,        // Tx request
  input wire logic               [7:0] int_mask,      // Mask
  input wire logic                     dma_mode,      // DMA mode
  input wire logic               [7:0] ev_in,         // Events
  input wire logic                     tx_avail       // Tx data
);
  logic       wr_q, rd_q;
  logic [3:0] wr_age, rd_age;

  // Clocks since the last read edge or write rise; saturates so stale edges never alias
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b1;
      rd_q <= 1'b1;
      wr_age <= 4'hf;
      rd_age <= 4'hf;
    end else begin
      wr_q <= bus_pins.wr_n;
      rd_q <= bus_pins.rd_n;
      wr_age <= (bus_pins.wr_n && !wr_q) ? 4'h0 : wr_age + {3'h0, wr_age != 4'hf};
      rd_age <= (bus_pins.rd_n != rd_q) ? 4'h0 : rd_age + {3'h0, rd_age != 4'hf};
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_reset_quiet: assert property ($rose(rst_n) |-> int_n && !drq_rx && !drq_tx)
    else $error("outputs active after reset");
  a_read_drives: assert property ($fell(bus_pins.rd_n) && !bus_pins.cs_n |-> ##[2:4] host_rdata_oe)
    else $error("selected read not driven");
  a_idle_quiet: assert property (bus_pins.rd_n [*5] |-> !host_rdata_oe)
    else $error("data driven without read");
  a_event_raises: assert property (|(ev_in & ~int_mask) |-> ##[1:2] !int_n)
    else $error("unmasked event gave no interrupt");
  a_mask_hides: assert property ((int_mask == 8'hff) [*3] |-> int_n)
    else $error("interrupt while all masked");
  a_tx_req_mode: assert property ($rose(drq_tx) |-> dma_mode)
    else $error("tx request outside dma mode");
  a_tx_drop_write: assert property ($fell(drq_tx) |-> wr_age <= 4'h6)
    else $error("tx request fell away from a write");
  a_rx_drop_read: assert property ($fell(drq_rx) |-> rd_age <= 4'h6)
    else $error("rx request fell away from a read");
  a_tx_push_write: assert property ($rose(tx_avail) |-> wr_age <= 4'h7)
    else $error("tx data without a write");
endmodule : hdlchp_port_properties

bind hdlchp_port hdlchp_port_properties #(.CNT_W(CNT_W)) u_props (
  .mclk(mclk), .rst_n(rst_n), .bus_pins(bus_pins), .host_rdata_oe(host_rdata_oe),
  .int_n(int_n), .drq_rx(drq_rx), .drq_tx(drq_tx), .int_mask(int_mask),
  .dma_mode(dma_mode), .ev_in(ev_in), .tx_avail(tx_avail));
`default_nettype wire

// [test/hdlchp_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module hdlchp_host_model (
  input  wire logic                     mclk,       // Clock
  input  wire logic               [7:0] host_rdata, // Read data
  output var  hdlchp_pkg::hdlchp_pins_t bus_pins    // Bus pins
);
  initial bus_pins = hdlchp_pkg::PINS_IDLE;

  // One strobe cycle; sel 0 select, 1 acknowledge, 2 neither. Held 4 clocks.
  task automatic xfer(input logic [1:0] sel, input logic rd, input logic [6:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(negedge mclk);
    bus_pins <= '{cs_n: sel != 2'd0, rd_n: !rd, wr_n: rd, dma_acknowledge_n: sel != 2'd1,
                  addr: a, wdata: d};
    repeat (4) @(negedge mclk);
    q = host_rdata;
    bus_pins.rd_n <= 1'b1;
    bus_pins.wr_n <= 1'b1;
    @(negedge mclk);
    // Released lines show the inverse so stale values never look valid
    bus_pins <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, dma_acknowledge_n: 1'b1, addr: ~a, wdata: ~d};
    repeat (3) @(negedge mclk);
  endtask : xfer
endmodule : hdlchp_host_model
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        mclk, rst_n, dma_mode, tx_start, rx_confirm, tx_pop, oe, int_n;
  logic        drq_rx, drq_tx, rx_full, tx_avail;
  logic [7:0]  int_mask, ev_in, host_rdata, tx_byte, r;
  logic [1:0]  rx_blk_sel;
  logic [15:0] tx_byte_count;
  logic [7:0]  q[$];
  int          mismatches, n_tests, cyc, falls, exp_falls;
  int          cpos[8] = '{-1, 0, 1, -1, 2, -1, -1, -1};
  int          xpos[8] = '{0, -1, -1, 1, -1, 2, 3, 4};
  hdlchp_pkg::hdlchp_pins_t bus_pins;
  hdlchp_pkg::hdlchp_byte_t rx_push;

  hdlchp_port #(.CNT_W(16)) DUT (
    .mclk(mclk), .rst_n(rst_n), .bus_pins(bus_pins), .host_rdata(host_rdata),
    .host_rdata_oe(oe), .int_n(int_n), .drq_rx(drq_rx), .drq_tx(drq_tx),
    .int_mask(int_mask), .dma_mode(dma_mode), .rx_blk_sel(rx_blk_sel),
    .tx_start(tx_start), .tx_byte_count(tx_byte_count), .rx_confirm(rx_confirm),
    .ev_in(ev_in), .rx_push(rx_push), .rx_full(rx_full), .tx_pop(tx_pop),
    .tx_byte(tx_byte), .tx_avail(tx_avail));
  hdlchp_host_model host (.mclk(mclk), .host_rdata(host_rdata), .bus_pins(bus_pins));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Each drop of the tx request is counted against the block plan
  always @(negedge drq_tx) falls++;

  // A hang ends the run as a failure
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic summarize;
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  task automatic wait_req(input logic tx);
    int k;
    k = 0;
    while ((tx ? drq_tx : drq_rx) !== 1'b1 && k < 300) begin
      @(negedge mclk);
      k++;
    end
    check({7'h0, tx ? drq_tx : drq_rx}, 8'h01);
  endtask : wait_req

  task automatic push(input int n);
    repeat (n) begin
      r = 8'($urandom);
      q.push_back(r);
      rx_push <= '{valid: 1'b1, data: r};
      @(negedge mclk);
    end
    rx_push <= '{valid: 1'b0, data: 8'h00};
  endtask : push

  // Reads at random window addresses; under acknowledge any address at all
  task automatic pull(input int n, input logic [1:0] sel);
    repeat (n) begin
      host.xfer(sel, 1'b1, 7'($urandom) & (sel[0] ? 7'h7f : 7'h1f), 8'h00, r);
      check(r, q.pop_front());
    end
  endtask : pull

  task automatic drain;
    while (q.size() > 0) begin
      check({7'h0, tx_avail}, 8'h01);
      check(tx_byte, q.pop_front());
      tx_pop <= 1'b1;
      @(negedge mclk);
      tx_pop <= 1'b0;
      repeat (2) @(negedge mclk);
    end
    check({7'h0, tx_avail}, 8'h00);
  endtask : drain

  initial begin
    void'($urandom(32'hb587));
    rst_n = 1'b0;
    {dma_mode, tx_start, rx_confirm, tx_pop} = 4'h0;
    int_mask = 8'h00;
    ev_in = 8'h00;
    rx_blk_sel = 2'h3;
    tx_byte_count = 16'h0000;
    rx_push = '{valid: 1'b0, data: 8'h00};
    repeat (3) @(negedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(negedge mclk);
    check({6'h0, rx_full, tx_avail}, 8'h00);
    // Every source: hidden while masked, then flagged and cleared by reading
    for (int i = 0; i < 8; i++) begin
      int_mask <= 8'hff;
      ev_in <= 8'h01 << i;
      @(negedge mclk);
      ev_in <= 8'h00;
      repeat (3) @(negedge mclk);
      check({7'h0, int_n}, 8'h01);
      host.xfer(2'd0, 1'b1, hdlchp_pkg::TOP_STAT_ADDR, 8'h00, r);
      check(r, 8'h00);
      int_mask <= 8'h00;
      repeat (3) @(negedge mclk);
      check({7'h0, int_n}, 8'h00);
      host.xfer(2'd0, 1'b1, hdlchp_pkg::TOP_STAT_ADDR, 8'h00, r);
      check(r, cpos[i] >= 0 ? 8'h01 : 8'h02);
      host.xfer(2'd0, 1'b1, cpos[i] >= 0 ? hdlchp_pkg::CHAN_STAT_ADDR :
                hdlchp_pkg::EXT_STAT_ADDR, 8'h00, r);
      check(r, 8'h01 << (cpos[i] >= 0 ? cpos[i] : xpos[i]));
      check({7'h0, int_n}, 8'h01);
    end
    // An unmasked event pulls the line low at once; one read clears it
    ev_in <= 8'h80;
    @(negedge mclk);
    ev_in <= 8'h00;
    @(negedge mclk);
    check({7'h0, int_n}, 8'h00);
    host.xfer(2'd0, 1'b1, hdlchp_pkg::EXT_STAT_ADDR, 8'h00, r);
    check(r, 8'h10);
    check({7'h0, int_n}, 8'h01);
    // Unselected write dropped; selected ones land wherever in the window
    host.xfer(2'd2, 1'b0, hdlchp_pkg::TX_WIN_BASE, 8'h5a, r);
    check({7'h0, tx_avail}, 8'h00);
    repeat (3) begin
      r = 8'($urandom);
      q.push_back(r);
      host.xfer(2'd0, 1'b0, hdlchp_pkg::TX_WIN_BASE | (7'($urandom) & 7'h1f), r, r);
    end
    drain();
    // Interrupt mode: 32 bytes raise pool full, read back, then confirmed
    push(32);
    repeat (4) @(negedge mclk);
    check({7'h0, int_n}, 8'h00);
    host.xfer(2'd0, 1'b1, hdlchp_pkg::CHAN_STAT_ADDR, 8'h00, r);
    check(r, 8'h01);
    pull(32, 2'd0);
    rx_confirm <= 1'b1;
    @(negedge mclk);
    rx_confirm <= 1'b0;
    // Receive DMA blocks of 4, 8, 16 and 32 bytes
    dma_mode <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      rx_blk_sel <= 2'(s);
      push(4 << s);
      wait_req(1'b0);
      pull(4 << s, 2'd1);
      repeat (4) @(negedge mclk);
      check({7'h0, drq_rx}, 8'h00);
    end
    // Demand-mode transmit: short block under acknowledge, long one under select
    for (int n = 2; n < 40; n += 31) begin
      tx_byte_count <= 16'(n);
      tx_start <= 1'b1;
      @(negedge mclk);
      tx_start <= 1'b0;
      falls = 0;
      exp_falls = (n / 32) * 2 + ((n % 32) > 1 ? 2 : 1);
      for (int k = 0; k < n; k++) begin
        wait_req(1'b1);
        r = 8'($urandom);
        q.push_back(r);
        host.xfer(n > 32 ? 2'd0 : 2'd1, 1'b0,
                  (n > 32 ? hdlchp_pkg::TX_WIN_BASE : 7'($urandom)) |
                  (7'($urandom) & 7'h1f), r, r);
      end
      repeat (8) @(negedge mclk);
      check({7'h0, drq_tx}, 8'h00);
      check(8'(falls), 8'(exp_falls));
      drain();
    end
    summarize();
  end
endmodule : tb
`default_nettype wire
